// ==== include/adcc_pkg.sv ====
// shared constants and types of the converter control block
package adcc_pkg;
  localparam int CH_COUNT   = 8;
  localparam int CODE_W     = 12;
  localparam int AVG_W      = 16;
  localparam int REG_W      = 16;
  localparam int LINK_BYTES = 3;

  localparam int CLK_PERIOD_NS    = 10;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int SAMPLE_CYCLES    =
    (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_GENERAL   = 8'h01;
  localparam logic [7:0] ADDR_AVG       = 8'h02;
  localparam logic [7:0] ADDR_MANUAL_CH = 8'h03;
  localparam logic [7:0] ADDR_FUNC      = 8'h04;
  localparam logic [7:0] ADDR_DIR       = 8'h05;
  localparam logic [7:0] ADDR_DRIVE     = 8'h06;
  localparam logic [7:0] ADDR_OUT_LEVEL = 8'h07;
  localparam logic [7:0] ADDR_IN_LEVEL  = 8'h08;
  localparam logic [7:0] ADDR_SEQ_MASK  = 8'h09;
  localparam logic [7:0] ADDR_RESULT    = 8'h0a;
  localparam logic [7:0] ADDR_RESULT_CH = 8'h0b;
  localparam logic [7:0] ADDR_THR_HIGH  = 8'h0c;
  localparam logic [7:0] ADDR_THR_LOW   = 8'h0d;

  localparam int GEN_CAL    = 0;
  localparam int GEN_CHECK  = 1;
  localparam int GEN_AUTO   = 2;
  localparam int GEN_HALT   = 3;
  localparam int GEN_ALERT  = 4;
  localparam int GEN_START  = 5;
  localparam int GEN_SUFFIX = 6;
  localparam int GEN_WINDOW = 8;
  localparam int GEN_W      = 9;

  localparam int ST_ERR   = 0;
  localparam int ST_BUSY  = 1;
  localparam int ST_VALID = 2;
  localparam int ST_HIGH  = 3;
  localparam int ST_LOW   = 4;

  localparam logic [GEN_W-1:0]  GEN_RST      = 9'h000;
  localparam logic [7:0]        CH_CFG_RST   = 8'h00;
  localparam logic [CODE_W-1:0] THR_HIGH_RST = 12'hfff;
  localparam logic [CODE_W-1:0] THR_LOW_RST  = 12'h000;
  localparam logic [2:0]        LINK_IDLE    = 3'h2;
  localparam int                LINK_WR_BIT  = 23;

  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  localparam logic [1:0] SUFFIX_CHID   = 2'h1;
  localparam logic [1:0] SUFFIX_STATUS = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE, S_CAL, S_REQ, S_WAIT, S_GAP
  } adcc_state_type;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       sdi;
  } adcc_link_type;

  typedef struct packed {
    logic       start;
    logic       cal;
    logic [2:0] channel;
  } adcc_conv_req_type;

  typedef struct packed {
    logic              done;
    logic              cal_done;
    logic [CODE_W-1:0] code;
  } adcc_conv_rsp_type;
endpackage

// ==== rtl/adcc_crc8.sv ====
// crc-8 of one byte from a zero seed
module adcc_crc8
  import adcc_pkg::*;
#(
  parameter logic [7:0] POLY = CRC_POLY
) (
  input  wire logic [7:0] data,
  output logic      [7:0] crc
);
  always_comb begin
    crc = CRC_INIT ^ data;
    for (int i = 0; i < 8; i++) begin
      crc = crc[7] ? ((crc << 1) ^ POLY) : (crc << 1);
    end
  end
endmodule

// ==== rtl/adcc_top.sv ====
// channel, averaging, serial check and pin control of the converter
// Function
// R1 - after reset all eight channels are analog inputs
// R2 - function, direction and drive bits select analog, input, od or pp
// R3 - results are 12-bit unsigned straight binary codes
// R4 - codes pass through unchanged so 000, 800, fff map directly
// R5 - calibration bit starts calibration and clears itself when done
// R6 - one three-bit averaging ratio serves every analog channel
// R7 - averaged result is 16 bits with finer step
// R8 - host starts first conversion; follow-on conversions are internal
// R9 - averaged result is updated only after all samples are taken
// R10 - autonomous mode averages each masked channel in turn
// R11 - window comparator uses top 12 bits of averaged result
// R12 - with checking on, every sent and received byte has check byte
// R13 - check byte uses polynomial x^8 + x^2 + x + 1
// R14 - checking acts only while the check enable bit is set
// R15 - bad check byte discards data and sets inbound error flag
// R16 - writes are refused until error flag cleared by writing one
// R17 - alert enable raises alarm on inbound error
// R18 - suffix select 10b appends four status bits to read frame
// R19 - halt bit stops autonomous conversions after inbound error
// R20 - digital outputs drive the written output level
// R21 - input level reads real pin level of digital channels
// R22 - read data msb first, 16 or 12 bits plus 4-bit suffix
// R23 - analog channels read 0 and ignore output level
//
// Added by the designer: the plain strobed port and the register addresses.
module adcc_top
  import adcc_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [REG_W-1:0]  reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [REG_W-1:0]  reg_rdata,
  input  wire adcc_link_type     link_in,
  output logic                   sdo,
  output logic                   sdo_oe,
  output adcc_conv_req_type      conv_req,
  input  wire adcc_conv_rsp_type conv_rsp,
  input  wire logic [7:0]        pin_in,
  output logic      [7:0]        pin_out,
  output logic      [7:0]        pin_oe,
  output logic                   alarm
);
  // first circular channel after cur that the mask allows
  function automatic logic [2:0] next_ch(input logic [7:0] m,
                                         input logic [2:0] cur);
    logic [2:0] r;
    logic       found;
    r     = cur;
    found = 1'b0;
    for (int i = 1; i <= CH_COUNT; i++) begin
      if (!found && m[3'(cur + 3'(i))]) begin
        r     = 3'(cur + 3'(i));
        found = 1'b1;
      end
    end
    return r;
  endfunction

  logic [2:0]        lk_meta_reg;
  logic [2:0]        lk_sync_reg;
  logic [2:0]        lk_prev_reg;
  logic [7:0]        pin_meta_reg;
  logic [7:0]        pin_sync_reg;
  logic [GEN_W-1:0]  gen_reg;
  logic [2:0]        avg_reg;
  logic [2:0]        man_ch_reg;
  logic [7:0]        func_reg;
  logic [7:0]        dir_reg;
  logic [7:0]        drive_reg;
  logic [7:0]        out_lvl_reg;
  logic [7:0]        seq_reg;
  logic [CODE_W-1:0] thr_hi_reg;
  logic [CODE_W-1:0] thr_lo_reg;
  logic              err_reg;
  logic              valid_reg;
  logic              hi_reg;
  logic              lo_reg;
  logic              start_pend_reg;
  adcc_state_type    state_reg;
  logic [2:0]        chan_reg;
  logic [2:0]        ratio_run_reg;
  logic [7:0]        cnt_reg;
  logic [18:0]       acc_reg;
  logic [AVG_W-1:0]  result_reg;
  logic [2:0]        res_ch_reg;
  logic              res_avg_reg;
  logic [$clog2(SAMPLE_CYC+1)-1:0] tick_cnt_reg;
  logic [7:0]        in_shift_reg;
  logic [7:0]        in_hold_reg;
  logic [2:0]        in_bits_reg;
  logic              in_crcph_reg;
  logic [1:0]        in_bytes_reg;
  logic              in_bad_reg;
  logic [23:0]       in_word_reg;
  logic              link_wr_reg;
  logic [7:0]        out_byte_reg;
  logic [7:0]        out_hold_reg;
  logic [2:0]        out_bits_reg;
  logic              out_crcph_reg;
  logic [1:0]        out_idx_reg;
  logic [23:0]       out_word_reg;
  logic [7:0]        in_crc;
  logic [7:0]        out_crc;

  // link pins are sampled, their edges found on mclk
  wire sclk_s   = lk_sync_reg[2];
  wire cs_n_s   = lk_sync_reg[1];
  wire sdi_s    = lk_sync_reg[0];
  wire active   = ~cs_n_s;
  wire cs_fall  = ~cs_n_s & lk_prev_reg[1];
  wire cs_rise  = cs_n_s & ~lk_prev_reg[1];
  wire sclk_up  = active & sclk_s & ~lk_prev_reg[2];
  wire sclk_dn  = active & ~sclk_s & lk_prev_reg[2];
  // R14 checking gate
  wire check_en = gen_reg[GEN_CHECK];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lk_meta_reg  <= LINK_IDLE;
      lk_sync_reg  <= LINK_IDLE;
      lk_prev_reg  <= LINK_IDLE;
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end else begin
      lk_meta_reg  <= {link_in.sclk, link_in.cs_n, link_in.sdi};
      lk_sync_reg  <= lk_meta_reg;
      lk_prev_reg  <= lk_sync_reg;
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // R13 check bytes for both directions
  adcc_crc8 #(.POLY(CRC_POLY)) u_in_crc (
    .data (in_hold_reg),
    .crc  (in_crc)
  );
  adcc_crc8 #(.POLY(CRC_POLY)) u_out_crc (
    .data (out_hold_reg),
    .crc  (out_crc)
  );

  // inbound byte assembly; mismatch poisons the whole frame
  wire [7:0] in_next   = {in_shift_reg[6:0], sdi_s};
  wire       in_last   = sclk_up & (in_bits_reg == 3'd7);
  // R15 mismatch on inbound check byte
  wire       mismatch  = in_last & in_crcph_reg & (in_next != in_crc);
  wire       frame_ok  = (in_bytes_reg == 2'(LINK_BYTES)) & ~in_bad_reg
                         & ~in_crcph_reg & in_word_reg[LINK_WR_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_shift_reg <= 8'h00;
      in_hold_reg  <= 8'h00;
      in_bits_reg  <= 3'd0;
      in_crcph_reg <= 1'b0;
      in_bytes_reg <= 2'd0;
      in_bad_reg   <= 1'b0;
      in_word_reg  <= 24'h000000;
      link_wr_reg  <= 1'b0;
    end else begin
      // R15 discard the frame's write
      link_wr_reg <= cs_rise & frame_ok;
      if (cs_fall) begin
        in_bits_reg  <= 3'd0;
        in_crcph_reg <= 1'b0;
        in_bytes_reg <= 2'd0;
        in_bad_reg   <= 1'b0;
      end else if (sclk_up) begin
        in_shift_reg <= in_next;
        in_bits_reg  <= in_bits_reg + 3'd1;
        if (in_last && in_crcph_reg) begin
          in_crcph_reg <= 1'b0;
          in_bad_reg   <= in_bad_reg | mismatch;
          in_bytes_reg <= in_bytes_reg + 2'd1;
        end else if (in_last && in_bytes_reg != 2'(LINK_BYTES)) begin
          in_word_reg <= {in_word_reg[15:0], in_next};
          in_hold_reg <= in_next;
          // R12 check byte expected after each data byte
          if (check_en) begin
            in_crcph_reg <= 1'b1;
          end else begin
            in_bytes_reg <= in_bytes_reg + 2'd1;
          end
        end
      end
    end
  end

  // write path: local port wins over a link write in the same cycle
  wire             any_wr = reg_wr | link_wr_reg;
  wire [7:0]       w_addr = reg_wr ? reg_addr : {1'b0, in_word_reg[22:16]};
  wire [REG_W-1:0] w_data = reg_wr ? reg_wdata : in_word_reg[15:0];
  // R16 lockout while error flag stands
  wire             wr_ok  = any_wr & ~err_reg;

  function automatic logic hit(input logic [7:0] a);
    return wr_ok && (w_addr == a);
  endfunction

  wire wr_status  = any_wr & (w_addr == ADDR_STATUS);
  wire wr_general = hit(ADDR_GENERAL);
  wire cal_done   = (state_reg == S_CAL) & conv_rsp.cal_done;
  wire conv_fin;
  wire [CODE_W-1:0] cmp_code;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // R1 all channels analog
      gen_reg     <= GEN_RST;
      avg_reg     <= 3'd0;
      man_ch_reg  <= 3'd0;
      func_reg    <= CH_CFG_RST;
      dir_reg     <= CH_CFG_RST;
      drive_reg   <= CH_CFG_RST;
      out_lvl_reg <= CH_CFG_RST;
      seq_reg     <= CH_CFG_RST;
      thr_hi_reg  <= THR_HIGH_RST;
      thr_lo_reg  <= THR_LOW_RST;
    end else begin
      if (wr_general) begin
        gen_reg <= {w_data[GEN_W-1:GEN_START+1], 1'b0, w_data[GEN_START-1:1],
                    w_data[GEN_CAL] | (gen_reg[GEN_CAL] & ~cal_done)};
      end else if (cal_done) begin
        // R5 self-clearing calibration bit
        gen_reg[GEN_CAL] <= 1'b0;
      end
      // R6 one ratio for all channels
      if (hit(ADDR_AVG))       avg_reg     <= w_data[2:0];
      if (hit(ADDR_MANUAL_CH)) man_ch_reg  <= w_data[2:0];
      if (hit(ADDR_FUNC))      func_reg    <= w_data[7:0];
      if (hit(ADDR_DIR))       dir_reg     <= w_data[7:0];
      if (hit(ADDR_DRIVE))     drive_reg   <= w_data[7:0];
      if (hit(ADDR_OUT_LEVEL)) out_lvl_reg <= w_data[7:0];
      if (hit(ADDR_SEQ_MASK))  seq_reg     <= w_data[7:0];
      if (hit(ADDR_THR_HIGH))  thr_hi_reg  <= w_data[CODE_W-1:0];
      if (hit(ADDR_THR_LOW))   thr_lo_reg  <= w_data[CODE_W-1:0];
    end
  end

  // R11 window compare on finished result
  wire wc_high = gen_reg[GEN_WINDOW] & conv_fin & (cmp_code > thr_hi_reg);
  wire wc_low  = gen_reg[GEN_WINDOW] & conv_fin & (cmp_code < thr_lo_reg);

  // flags: hardware set wins over a write-one clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg        <= 1'b0;
      valid_reg      <= 1'b0;
      hi_reg         <= 1'b0;
      lo_reg         <= 1'b0;
      start_pend_reg <= 1'b0;
    end else begin
      // R16 only a one written to the flag clears it
      err_reg   <= mismatch | (err_reg & ~(wr_status & w_data[ST_ERR]));
      valid_reg <= conv_fin | (valid_reg & ~(wr_status & w_data[ST_VALID]));
      hi_reg    <= wc_high | (hi_reg & ~(wr_status & w_data[ST_HIGH]));
      lo_reg    <= wc_low | (lo_reg & ~(wr_status & w_data[ST_LOW]));
      start_pend_reg <= (wr_general & w_data[GEN_START]) | (start_pend_reg
                        & (state_reg != S_IDLE | gen_reg[GEN_CAL]));
    end
  end

  // sample pacing divider, one-cycle tick
  wire tick = (tick_cnt_reg == ($bits(tick_cnt_reg))'(SAMPLE_CYC - 1));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
    end
  end

  // conversion sequencing
  wire [7:0]  usable    = seq_reg & ~func_reg;
  wire        idle      = (state_reg == S_IDLE);
  wire        cal_go    = idle & gen_reg[GEN_CAL];
  wire        man_go    = idle & start_pend_reg & ~cal_go;
  // R19 halt on inbound error
  wire        halted    = gen_reg[GEN_HALT] & err_reg;
  // R10 walk masked analog channels in turn
  wire        auto_go   = idle & gen_reg[GEN_AUTO] & tick & (|usable)
                          & ~halted & ~cal_go & ~start_pend_reg;
  wire [2:0]  auto_ch   = next_ch(usable, chan_reg);
  // R3 R4 plain binary code accumulated unchanged
  wire [18:0] acc_next  = acc_reg + {7'h00, conv_rsp.code};
  wire [7:0]  target    = 8'h01 << ratio_run_reg;
  wire        last_smp  = (cnt_reg + 8'h01) == target;
  wire        avg_run   = (ratio_run_reg != 3'd0);
  // R7 16-bit average: sum scaled by 16 then divided by count
  wire [22:0] scaled    = {acc_next, 4'h0} >> ratio_run_reg;
  wire [AVG_W-1:0] res_next = avg_run ? scaled[AVG_W-1:0]
                                      : {4'h0, conv_rsp.code};
  assign conv_fin = (state_reg == S_WAIT) & conv_rsp.done & last_smp;
  assign cmp_code = avg_run ? scaled[AVG_W-1:4] : conv_rsp.code;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= S_IDLE;
      chan_reg      <= 3'd0;
      ratio_run_reg <= 3'd0;
      cnt_reg       <= 8'h00;
      acc_reg       <= 19'h00000;
      result_reg    <= 16'h0000;
      res_ch_reg    <= 3'd0;
      res_avg_reg   <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (cal_go) begin
            // R5 calibration runs until the converter reports done
            state_reg <= S_CAL;
          end else if (man_go || auto_go) begin
            state_reg     <= S_REQ;
            chan_reg      <= man_go ? man_ch_reg : auto_ch;
            ratio_run_reg <= avg_reg;
            cnt_reg       <= 8'h00;
            acc_reg       <= 19'h00000;
          end
        end
        S_REQ: state_reg <= S_WAIT;
        S_WAIT: begin
          if (conv_rsp.done) begin
            acc_reg <= acc_next;
            cnt_reg <= cnt_reg + 8'h01;
            if (last_smp) begin
              // R9 result replaced only once averaging ends
              state_reg   <= S_IDLE;
              result_reg  <= res_next;
              res_ch_reg  <= chan_reg;
              res_avg_reg <= avg_run;
            end else begin
              state_reg <= S_GAP;
            end
          end
        end
        // R8 follow-on conversions started internally
        S_GAP: if (tick) state_reg <= S_REQ;
        S_CAL: if (conv_rsp.cal_done) state_reg <= S_IDLE;
      endcase
    end
  end

  assign conv_req.start   = (state_reg == S_REQ);
  assign conv_req.cal     = (state_reg == S_CAL);
  assign conv_req.channel = chan_reg;

  // R18 status suffix when select is 10b
  wire [1:0] sfx_sel = gen_reg[GEN_SUFFIX+1:GEN_SUFFIX];
  wire [3:0] suffix  = (sfx_sel == SUFFIX_STATUS)
                         ? {err_reg, hi_reg, lo_reg, valid_reg}
                       : (sfx_sel == SUFFIX_CHID) ? {1'b0, res_ch_reg}
                       : 4'h0;
  // R22 msb-aligned word, 16 or 12 bits then suffix
  wire [23:0] frame  = res_avg_reg ? {result_reg, suffix, 4'h0}
                                   : {result_reg[11:0], suffix, 8'h00};
  wire [7:0]  nxt_byte = (out_idx_reg == 2'd0) ? out_word_reg[15:8]
                       : (out_idx_reg == 2'd1) ? out_word_reg[7:0]
                       : 8'h00;

  // frame captured at select so a finishing conversion cannot tear it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_byte_reg  <= 8'h00;
      out_hold_reg  <= 8'h00;
      out_bits_reg  <= 3'd0;
      out_crcph_reg <= 1'b0;
      out_idx_reg   <= 2'd0;
      out_word_reg  <= 24'h000000;
    end else if (cs_fall) begin
      out_word_reg  <= frame;
      out_byte_reg  <= frame[23:16];
      out_hold_reg  <= frame[23:16];
      out_bits_reg  <= 3'd0;
      out_crcph_reg <= 1'b0;
      out_idx_reg   <= 2'd0;
    end else if (sclk_dn) begin
      out_bits_reg <= out_bits_reg + 3'd1;
      if (out_bits_reg != 3'd7) begin
        out_byte_reg <= {out_byte_reg[6:0], 1'b0};
      end else if (check_en && !out_crcph_reg) begin
        // R12 check byte after each sent byte
        out_byte_reg  <= out_crc;
        out_crcph_reg <= 1'b1;
      end else begin
        out_crcph_reg <= 1'b0;
        out_idx_reg   <= out_idx_reg + 2'd1;
        out_byte_reg  <= nxt_byte;
        out_hold_reg  <= nxt_byte;
      end
    end
  end

  assign sdo    = out_byte_reg[7];
  assign sdo_oe = active;

  // R2 R20 R23 open drain drives low only, analog never driven
  wire [7:0] dout_en = func_reg & dir_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;
    end else begin
      pin_out <= dout_en & drive_reg & out_lvl_reg;
      pin_oe  <= dout_en & (drive_reg | ~out_lvl_reg);
    end
  end

  // R17 alarm on inbound error
  assign alarm = (gen_reg[GEN_ALERT] & err_reg) | hi_reg | lo_reg;

  // R21 R23 real pin level of digital channels, zero for analog
  wire [7:0] in_level = pin_sync_reg & func_reg;
  wire [15:0] status  = {11'h000, lo_reg, hi_reg, valid_reg, ~idle, err_reg};
  wire [15:0] rd_mux  =
      (reg_addr == ADDR_STATUS)    ? status
    : (reg_addr == ADDR_GENERAL)   ? {7'h00, gen_reg}
    : (reg_addr == ADDR_AVG)       ? {13'h0000, avg_reg}
    : (reg_addr == ADDR_MANUAL_CH) ? {13'h0000, man_ch_reg}
    : (reg_addr == ADDR_FUNC)      ? {8'h00, func_reg}
    : (reg_addr == ADDR_DIR)       ? {8'h00, dir_reg}
    : (reg_addr == ADDR_DRIVE)     ? {8'h00, drive_reg}
    : (reg_addr == ADDR_OUT_LEVEL) ? {8'h00, out_lvl_reg}
    : (reg_addr == ADDR_IN_LEVEL)  ? {8'h00, in_level}
    : (reg_addr == ADDR_SEQ_MASK)  ? {8'h00, seq_reg}
    : (reg_addr == ADDR_RESULT)    ? result_reg
    : (reg_addr == ADDR_RESULT_CH) ? {13'h0000, res_ch_reg}
    : (reg_addr == ADDR_THR_HIGH)  ? {4'h0, thr_hi_reg}
    : (reg_addr == ADDR_THR_LOW)   ? {4'h0, thr_lo_reg}
    : 16'h0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end
endmodule

// ==== verif/adcc_asserts.sv ====
// port checker of the converter control block
module adcc_asserts
  import adcc_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic [7:0]        reg_addr,
  input wire logic [REG_W-1:0]  reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [REG_W-1:0]  reg_rdata,
  input wire adcc_link_type     link_in,
  input wire logic              sdo,
  input wire logic              sdo_oe,
  input wire adcc_conv_req_type conv_req,
  input wire adcc_conv_rsp_type conv_rsp,
  input wire logic [7:0]        pin_in,
  input wire logic [7:0]        pin_out,
  input wire logic [7:0]        pin_oe,
  input wire logic              alarm
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rd_in_reg;
  logic go_wr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign go_wr = reg_wr && reg_addr == ADDR_GENERAL && reg_wdata[GEN_START];
  always_ff @(posedge mclk)
    rd_in_reg <= reg_rd && reg_addr == ADDR_IN_LEVEL;
  a_reset_pins_off: assert property ($rose(rst_n) |-> pin_oe == 8'h00 && !alarm)
    else $error("pins driven after reset");
  a_start_one_pulse: assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
  a_cal_holds: assert property (conv_req.cal && !conv_rsp.cal_done |=> conv_req.cal)
    else $error("calibration dropped early");
  a_cal_clears: assert property (conv_req.cal && conv_rsp.cal_done && !reg_wr |=> !conv_req.cal)
    else $error("calibration not cleared");
  a_inlvl_narrow: assert property (rd_in_reg |-> reg_rdata[15:8] == 8'h00)
    else $error("input level upper byte set");
  a_sdo_idle: assert property (link_in.cs_n [*4] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  a_sdo_active: assert property (!link_in.cs_n [*4] |-> sdo_oe)
    else $error("sdo not driven while selected");
  a_start_follows: assert property (go_wr && !reg_wdata[GEN_CAL]
    && !conv_req.cal && !alarm |-> ##[1:3] conv_req.start)
    else $error("host start not issued");
  c_start: cover property (conv_req.start);
  c_cal: cover property (conv_req.cal);
  c_alarm: cover property (alarm);
endmodule
bind adcc_top adcc_asserts chk (.*);

// ==== verif/adcc_conv_model.sv ====
// converter model answering start and calibration requests
module adcc_conv_model
  import adcc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire adcc_conv_req_type req,
  input  wire logic [CODE_W-1:0] code_val,
  output adcc_conv_rsp_type      rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] sd_reg;
  logic [2:0] cd_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sd_reg <= 3'h0;
      cd_reg <= 3'h0;
      rsp    <= '0;
    end else begin
      sd_reg <= {sd_reg[1:0], req.start};
      rsp.done <= sd_reg[2];
      // code only valid beside done, garbage otherwise
      rsp.code <= sd_reg[2] ? code_val : ~rsp.code;
      cd_reg <= (req.cal && !rsp.cal_done) ? cd_reg + 3'h1 : 3'h0;
      rsp.cal_done <= cd_reg == 3'h5;
    end
  end
endmodule

// ==== verif/adcc_top_tb.sv ====
// testbench of the converter control block
module adcc_top_tb
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              mclk = 0;
  logic              rst_n = 0;
  logic              reg_wr = 0, reg_rd = 0, rd_seen = 0;
  logic [7:0]        reg_addr = '0;
  logic [7:0]        pin_ext = '0;
  logic [REG_W-1:0]  reg_wdata = '0;
  logic [REG_W-1:0]  reg_rdata;
  logic [REG_W-1:0]  gen = '0;
  logic [CODE_W-1:0] code_val = '0;
  logic [CODE_W-1:0] codes[4];
  logic              sdo, sdo_oe, alarm;
  logic [7:0]        pin_out, pin_oe, pin_in;
  adcc_link_type     lk = '{1'b0, 1'b1, 1'b0};
  adcc_conv_req_type conv_req;
  adcc_conv_rsp_type conv_rsp;
  int                num_errors = 0;
  int                total_checks = 0;
  int                starts = 0;
  int                cyc = 0;
  int                r;
  integer            seed = 32'hb975;
  logic [REG_W-1:0]  expq[$];
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
  adcc_top #(.SAMPLE_CYC(4)) dut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_in(lk), .sdo(sdo),
    .sdo_oe(sdo_oe), .conv_req(conv_req), .conv_rsp(conv_rsp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alarm(alarm));
  adcc_conv_model conv (.mclk(mclk), .rst_n(rst_n), .req(conv_req),
    .code_val(code_val), .rsp(conv_rsp));
  initial forever #5 mclk = ~mclk;
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [REG_W-1:0] g, input logic [REG_W-1:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    starts <= starts + conv_req.start;
    rd_seen <= reg_rd;
    if (cyc == 30000) begin
      num_errors++;
      end_of_test;
    end
  end
  // read data stand only in the cycle after the strobe
  always @(negedge mclk) if (rd_seen) chk(reg_rdata, expq.pop_front());
  task automatic wr(input logic [7:0] a, input logic [REG_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [REG_W-1:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    expq.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  // x^8 + x^2 + x + 1 from a zero seed
  function automatic logic [7:0] crc(input logic [7:0] b);
    repeat (8) b = b[7] ? (b << 1) ^ 8'h07 : b << 1;
    return b;
  endfunction
  // link clock free of mclk, 125 ns period; sdo taken at sclk rise
  task automatic sbyte(input logic [7:0] b, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      lk.sdi <= b[i];
      #62.5;
      lk.sclk <= 1'b1;
      got = {got[6:0], sdo};
      #62.5;
      lk.sclk <= 1'b0;
    end
  endtask
  // each byte followed by its check byte, last one may be spoilt
  task automatic spi(input logic [23:0] f, input logic [7:0] bad,
                     input logic [23:0] o);
    logic [7:0] g;
    @(posedge mclk);
    lk.cs_n <= 1'b0;
    for (int k = 2; k >= 0; k--) begin
      sbyte(f[k*8 +: 8], g);
      chk(16'(g), 16'(o[k*8 +: 8]));
      sbyte(crc(f[k*8 +: 8]) ^ (k == 0 ? bad : 8'h00), g);
      chk(16'(g), 16'(crc(o[k*8 +: 8])));
    end
    repeat (6) @(posedge mclk);
    lk.cs_n <= 1'b1;
    lk.sdi <= ~lk.sdi;
    repeat (8) @(posedge mclk);
  endtask
  // one host start, the rest must come from inside
  task automatic conv_run(input int n);
    int s0;
    s0 = starts;
    wr(ADDR_GENERAL, gen | 16'h0020);
    for (int i = 0; i < 400 && starts - s0 < n; i++) @(posedge mclk);
    repeat (20) @(posedge mclk);
    chk(16'(starts - s0), 16'(n));
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    pin_ext <= 8'($random(seed));
    codes = '{12'h000, 12'h800, 12'hfff, 12'($random(seed))};
    rd(ADDR_FUNC, 16'h0000);
    rd(ADDR_IN_LEVEL, 16'h0000);
    rd(ADDR_THR_HIGH, 16'h0fff);
    chk(16'(pin_oe), 16'h0000);
    $display("test reset done");
    wr(ADDR_FUNC, 16'h00f0);
    wr(ADDR_DIR, 16'h00c0);
    wr(ADDR_DRIVE, 16'h0080);
    wr(ADDR_OUT_LEVEL, 16'h00ff);
    repeat (4) @(posedge mclk);
    chk({pin_oe, pin_out & pin_oe}, 16'h8080);
    wr(ADDR_OUT_LEVEL, 16'h0000);
    repeat (4) @(posedge mclk);
    chk({pin_oe, pin_out & pin_oe}, 16'hc000);
    rd(ADDR_IN_LEVEL, {10'h000, pin_ext[5:4], 4'h0});
    $display("test pins done");
    wr(ADDR_MANUAL_CH, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      r = (i % 2) * 2;
      code_val <= codes[i/2];
      wr(ADDR_AVG, 16'(r));
      conv_run(1 << r);
      rd(ADDR_RESULT, r ? {codes[i/2], 4'h0} : {4'h0, codes[i/2]});
    end
    rd(ADDR_RESULT_CH, 16'h0002);
    wr(ADDR_GENERAL, 16'h0001);
    rd(ADDR_GENERAL, 16'h0001);
    repeat (20) @(posedge mclk);
    rd(ADDR_GENERAL, 16'h0000);
    gen = 16'h0100;
    wr(ADDR_THR_HIGH, 16'h07ff);
    code_val <= 12'h800;
    conv_run(4);
    rd(ADDR_STATUS, 16'h000c);
    chk(16'(alarm), 16'h0001);
    wr(ADDR_STATUS, 16'h0018);
    rd(ADDR_STATUS, 16'h0004);
    $display("test conversion done");
    wr(ADDR_GENERAL, 16'h0092);
    spi({1'b1, ADDR_SEQ_MASK[6:0], 16'h0055}, 8'h00, 24'h800010);
    rd(ADDR_SEQ_MASK, 16'h0055);
    spi({1'b1, ADDR_SEQ_MASK[6:0], 16'h00aa}, 8'h01, 24'h800010);
    rd(ADDR_SEQ_MASK, 16'h0055);
    rd(ADDR_STATUS, 16'h0005);
    chk(16'(alarm), 16'h0001);
    wr(ADDR_SEQ_MASK, 16'h0033);
    rd(ADDR_SEQ_MASK, 16'h0055);
    wr(ADDR_STATUS, 16'h0001);
    wr(ADDR_SEQ_MASK, 16'h0033);
    rd(ADDR_SEQ_MASK, 16'h0033);
    @(posedge mclk);
    $display("test link done");
    end_of_test;
  end
endmodule
